// File: dss_top.sv
/*
  Digital sequencing and supervision of a two-rail step-down controller:
  oscillator and sync, mode decode, rail ordering, power-good timer,
  latched protection and forced-PWM controls; two rail slices below.
  Assumes pins and analog comparators are asynchronous to clk_in and that
  the three-level order pin arrives decoded as a two-bit code.
*/
`timescale 1ns/1ps
module dss_top import dss_pkg::*; #(
  parameter int unsigned PG_CYCLES = PG_DELAY_CYCLES,
  parameter int unsigned UV_ARM = UV_ARM_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic shutdown_n_in,
  input wire logic master_on_low_rail_in,
  input wire logic delay_or_on_high_rail_in,
  input wire logic freq_sel_in,
  input wire logic forced_pwm_in,
  input wire logic internal_5v_rail_ok_in,
  input wire logic input_power_ok_in,
  input wire logic [1:0] order_select_in,
  input wire dss_cmp_t cmp_low_in,
  input wire dss_cmp_t cmp_high_in,
  output dss_drive_t drive_low_out,
  output dss_drive_t drive_high_out,
  output logic [2:0] ss_step_low_out,
  output logic [2:0] ss_step_high_out,
  output logic rail_low_en_out,
  output logic rail_high_en_out,
  output logic power_good_out,
  output logic delay_discharge_out,
  output logic min_current_cmp_en_out,
  output logic reverse_thresh_shift_out,
  output logic uv_latched_out,
  output logic ov_latched_out
);

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  dss_pins_t pins_raw, pins_m, pins;
  dss_cmp_t cmp_low_m, cmp_low, cmp_high_m, cmp_high;

  assign pins_raw = '{shutdown_n: shutdown_n_in,
                      master_on_low_rail: master_on_low_rail_in,
                      delay_or_on_high_rail: delay_or_on_high_rail_in,
                      freq_sel: freq_sel_in,
                      forced_pwm: forced_pwm_in,
                      internal_5v_rail_ok: internal_5v_rail_ok_in,
                      input_power_ok: input_power_ok_in,
                      order_select: order_select_in};

  // Two stages; nothing reads the first stage but the second
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pins_m <= '0;
      pins <= '0;
      cmp_low_m <= '0;
      cmp_low <= '0;
      cmp_high_m <= '0;
      cmp_high <= '0;
    end else begin
      pins_m <= pins_raw;
      pins <= pins_m;
      cmp_low_m <= cmp_low_in;
      cmp_low <= cmp_low_m;
      cmp_high_m <= cmp_high_in;
      cmp_high <= cmp_high_m;
    end
  end

  // ----------------------------------------------------------------------
  // Oscillator divider with sync restart
  // ----------------------------------------------------------------------
  logic [7:0] osc_cnt, next_osc_cnt;
  logic osc_pulse, next_osc_pulse;
  logic sel_prev;
  logic sync_fall;
  logic [7:0] osc_period, next_osc_period;

  assign sync_fall = sel_prev && !pins.freq_sel;

  // Falling select edge starts a fresh cycle at once. Rate is taken only
  // at a cycle start, so a sync clock's high phase cannot end a cycle
  // early; a static change to the high rate waits for the next cycle
  always_comb begin
    next_osc_pulse = sync_fall || (osc_cnt >= osc_period - 8'h01);
    next_osc_cnt = next_osc_pulse ? 8'h00 : osc_cnt + 8'h01;
    next_osc_period = osc_period;
    if (next_osc_pulse) begin
      next_osc_period = pins.freq_sel ? OSC_HIGH_PERIOD : OSC_LOW_PERIOD;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      osc_cnt <= 8'h00;
      osc_pulse <= 1'b0;
      sel_prev <= 1'b0;
      osc_period <= OSC_LOW_PERIOD;
    end else begin
      osc_cnt <= next_osc_cnt;
      osc_pulse <= next_osc_pulse;
      sel_prev <= pins.freq_sel;
      osc_period <= next_osc_period;
    end
  end

  // ----------------------------------------------------------------------
  // Mode decode and rail ordering
  // ----------------------------------------------------------------------
  logic in_shutdown, order_ref, standby, delay_done;
  logic next_en_low, next_en_high, en_low, en_high;

  assign in_shutdown = !pins.shutdown_n;
  // Unused code 2'h3 behaves as the reference setting
  assign order_ref = (pins.order_select != ORDER_VL) && (pins.order_select != ORDER_GND);
  assign delay_done = pins.delay_or_on_high_rail;
  assign standby = !in_shutdown && !pins.master_on_low_rail
                   && !(order_ref && pins.delay_or_on_high_rail);

  always_comb begin
    if (in_shutdown) begin
      next_en_low = 1'b0;
      next_en_high = 1'b0;
    end else if (order_ref) begin
      next_en_low = pins.master_on_low_rail;
      next_en_high = pins.delay_or_on_high_rail;
    end else if (pins.order_select == ORDER_VL) begin
      next_en_low = pins.master_on_low_rail;
      next_en_high = pins.master_on_low_rail && delay_done;
    end else begin
      next_en_high = pins.master_on_low_rail;
      next_en_low = pins.master_on_low_rail && delay_done;
    end
  end

  // ----------------------------------------------------------------------
  // Delay pin discharge
  // ----------------------------------------------------------------------
  logic [4:0] disch_cnt, next_disch_cnt;
  logic shutdown_n_prev;
  logic next_discharge, discharge;

  // Pulse also covers the first clocks after reset so a charged
  // timing capacitor cannot skip the inter-rail delay
  always_comb begin
    next_disch_cnt = disch_cnt;
    if (in_shutdown && !shutdown_n_prev) begin
      next_disch_cnt = DISCH_PULSE_CYC;
    end else if (disch_cnt != 5'h00) begin
      next_disch_cnt = disch_cnt - 5'h01;
    end
    next_discharge = standby || (next_disch_cnt != 5'h00);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      disch_cnt <= DISCH_PULSE_CYC;
      shutdown_n_prev <= 1'b0;
      discharge <= 1'b1;
      en_low <= 1'b0;
      en_high <= 1'b0;
    end else begin
      disch_cnt <= next_disch_cnt;
      shutdown_n_prev <= in_shutdown;
      discharge <= next_discharge;
      en_low <= next_en_low;
      en_high <= next_en_high;
    end
  end

  // ----------------------------------------------------------------------
  // Protection latches and power-good timer
  // ----------------------------------------------------------------------
  logic uv_latch, next_uv_latch, ov_latch, next_ov_latch;
  logic armed_low, armed_high, latch_clear, uv_set, ov_set;
  logic mon_ok, pg, next_pg;
  logic [14:0] pg_cnt, next_pg_cnt;
  logic fpwm, next_fpwm;

  assign latch_clear = in_shutdown || !pins.master_on_low_rail
                       || !pins.input_power_ok;
  assign uv_set = !in_shutdown && ((armed_low && cmp_low.under)
                  || (armed_high && cmp_high.under));
  assign ov_set = !in_shutdown && (cmp_low.over || cmp_high.over);
  assign mon_ok = !in_shutdown && cmp_low.in_reg
                  && (order_ref || cmp_high.in_reg);

  // A fault in the clearing cycle still latches, except in shutdown
  always_comb begin
    next_uv_latch = uv_set || (uv_latch && !latch_clear);
    next_ov_latch = ov_set || (ov_latch && !latch_clear);
    next_pg_cnt = pg_cnt;
    if (!mon_ok) begin
      next_pg_cnt = 15'h0000;
    end else if (osc_pulse && pg_cnt != 15'(PG_CYCLES)) begin
      next_pg_cnt = pg_cnt + 15'h0001;
    end
    next_pg = mon_ok && (pg_cnt == 15'(PG_CYCLES));
    next_fpwm = pins.forced_pwm;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      uv_latch <= 1'b0;
      ov_latch <= 1'b0;
      pg_cnt <= 15'h0000;
      pg <= 1'b0;
      fpwm <= 1'b0;
    end else begin
      uv_latch <= next_uv_latch;
      ov_latch <= next_ov_latch;
      pg_cnt <= next_pg_cnt;
      pg <= next_pg;
      fpwm <= next_fpwm;
    end
  end

  // ----------------------------------------------------------------------
  // Rail slices
  // ----------------------------------------------------------------------
  logic clamp, hold_low;

  assign clamp = uv_latch || ov_latch;
  // In shutdown, without the internal supply the drivers cannot be held up
  assign hold_low = !in_shutdown || pins.internal_5v_rail_ok;

  dss_rail #(.UV_ARM(UV_ARM)) u_rail_low (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .enable_in(en_low),
    .osc_pulse_in(osc_pulse),
    .clamp_in(clamp),
    .hold_low_in(hold_low),
    .cmp_in(cmp_low),
    .drive_out(drive_low_out),
    .ss_step_out(ss_step_low_out),
    .uv_armed_out(armed_low)
  );

  dss_rail #(.UV_ARM(UV_ARM)) u_rail_high (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .enable_in(en_high),
    .osc_pulse_in(osc_pulse),
    .clamp_in(clamp),
    .hold_low_in(hold_low),
    .cmp_in(cmp_high),
    .drive_out(drive_high_out),
    .ss_step_out(ss_step_high_out),
    .uv_armed_out(armed_high)
  );

  // Outputs
  assign rail_low_en_out = en_low;
  assign rail_high_en_out = en_high;
  assign power_good_out = pg;
  assign delay_discharge_out = discharge;
  assign min_current_cmp_en_out = !fpwm;
  assign reverse_thresh_shift_out = fpwm;
  assign uv_latched_out = uv_latch;
  assign ov_latched_out = ov_latch;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking dss_top_cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  chk_osc_period_run: assert property ((osc_cnt == osc_period - 8'h01 && !sync_fall)
    |=> osc_pulse && osc_cnt == 8'h00)
    else $error("oscillator period wrong");
  chk_sync_restart: assert property (sync_fall |=> osc_pulse ##1 osc_cnt == 8'h01)
    else $error("falling select did not restart cycle");
  chk_shutdown_off: assert property (in_shutdown |=> !en_low && !en_high)
    else $error("rail enabled in shutdown");
  chk_ref_independent: assert property ((order_ref && !in_shutdown)
    |=> en_high == $past(pins.delay_or_on_high_rail))
    else $error("independent rail control broken");
  chk_order_low_first: assert property ((pins.order_select == ORDER_VL && !in_shutdown)
    |=> !en_high || en_low)
    else $error("high rail before low rail");
  chk_standby_discharge: assert property (standby |=> delay_discharge_out)
    else $error("discharge off in standby");
  chk_pg_needs_regulation: assert property (power_good_out |-> $past(mon_ok))
    else $error("power-good high out of regulation");
  chk_pg_after_count: assert property ($rose(power_good_out)
    |-> $past(pg_cnt) == 15'(PG_CYCLES))
    else $error("power-good rose before count elapsed");
  chk_ov_drives_high: assert property (ov_latch |-> ##1 drive_low_out.low_side
    && drive_high_out.low_side)
    else $error("overvoltage did not hold low sides");
  chk_uv_rails_off: assert property (uv_latch |=> !drive_low_out.high_side
    && !drive_high_out.high_side)
    else $error("rail switching while latched off");
  chk_latch_holds: assert property ((ov_latch && !latch_clear) |=> ov_latch)
    else $error("protection latch cleared without cause");
  chk_forced_pwm: assert property (pins.forced_pwm |=> !min_current_cmp_en_out
    && reverse_thresh_shift_out)
    else $error("forced PWM controls wrong");

  cov_pg_rise: cover property ($rose(power_good_out));
  cov_ov_latch: cover property ($rose(ov_latch));
  cov_sync_fall: cover property (sync_fall);
  cov_gnd_order: cover property (pins.order_select == ORDER_GND && en_high && !en_low);

endmodule // dss_top

// File: dss_pkg.sv
/*
  Shared constants and carrier types of the dual-rail supply sequencer.
  Assumes a single 20 MHz system clock; all rates below derive from it.
*/
package dss_pkg;

  // ----------------------------------------------------------------------
  // Clock and oscillator timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_KHZ = 20000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned OSC_LOW_KHZ = 333;
  localparam int unsigned OSC_HIGH_KHZ = 500;
  // Whole clocks per oscillator period, rounded down
  localparam logic [7:0] OSC_LOW_PERIOD = 8'(CLK_KHZ / OSC_LOW_KHZ);
  localparam logic [7:0] OSC_HIGH_PERIOD = 8'(CLK_KHZ / OSC_HIGH_KHZ);
  // Minimum off-time, rounded up to whole clocks
  localparam int unsigned MIN_OFF_NS = 300;
  localparam logic [3:0] MIN_OFF_CYC =
    4'((MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------------
  // Counts in oscillator cycles (discharge pulse in clocks, SS_STEPS in soft-start levels)
  // ----------------------------------------------------------------------
  localparam int unsigned PG_DELAY_CYCLES = 32000;
  localparam int unsigned UV_ARM_CYCLES = 6144;
  localparam logic [9:0] SS_FULL_COUNT = 10'h200;
  localparam logic [12:0] SS_STEPS = 13'h0005;
  localparam logic [1:0] SKIP_MAX = 2'h3;
  // Length of the momentary discharge pulse, in clocks
  localparam logic [4:0] DISCH_PULSE_CYC = 5'h10;

  // ----------------------------------------------------------------------
  // Order select encoding (three-level pin decoded outside)
  // ----------------------------------------------------------------------
  localparam logic [1:0] ORDER_REF = 2'h0;
  localparam logic [1:0] ORDER_VL = 2'h1;
  localparam logic [1:0] ORDER_GND = 2'h2;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic in_reg;      // Output in regulation
    logic under;       // Output below 70% of nominal
    logic over;        // Output more than 7% above nominal
    logic cur_lim;     // Sensed current beyond +/-100 mV
    logic pwm_trip;    // Main PWM comparator ends the on-time
    logic reverse_cur; // Current fell through reverse threshold
  } dss_cmp_t;

  typedef struct packed {
    logic high_side;
    logic low_side;
  } dss_drive_t;

  typedef struct packed {
    logic shutdown_n;
    logic master_on_low_rail;
    logic delay_or_on_high_rail;
    logic freq_sel;
    logic forced_pwm;
    logic internal_5v_rail_ok;
    logic input_power_ok;
    logic [1:0] order_select;
  } dss_pins_t;

  typedef enum logic [3:0] {
    DSS_IDLE = 4'h1,
    DSS_ON = 4'h2,
    DSS_MINOFF = 4'h4,
    DSS_WAIT = 4'h8
  } dss_sw_state_t;

endpackage

// File: dss_rail.sv
/*
  One rail's switching, soft-start, dropout skipping and undervoltage arming.
  Assumes comparator inputs already synchronised and a one-clock oscillator
  pulse from the parent.
*/
`timescale 1ns/1ps
module dss_rail import dss_pkg::*; #(
  parameter int unsigned UV_ARM = UV_ARM_CYCLES
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic enable_in,
  input wire logic osc_pulse_in,
  input wire logic clamp_in,
  input wire logic hold_low_in,
  input wire dss_cmp_t cmp_in,
  output dss_drive_t drive_out,
  output logic [2:0] ss_step_out,
  output logic uv_armed_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  dss_sw_state_t state, next_state;
  logic [3:0] off_cnt, next_off_cnt;
  logic [1:0] skip_cnt, next_skip_cnt;
  logic pend, next_pend;
  logic [9:0] ss_cnt, next_ss_cnt;
  logic [12:0] arm_cnt, next_arm_cnt;
  logic ls, next_ls;
  logic [12:0] ss_prod;
  logic run;

  assign run = enable_in && !clamp_in;
  // Step = count*5/512, so level reaches 5 exactly at 512 oscillator cycles
  assign ss_prod = {3'h0, ss_cnt} * SS_STEPS;
  assign ss_step_out = ss_prod[11:9];
  assign uv_armed_out = (arm_cnt == 13'(UV_ARM));
  // One driver for the whole struct; separate field drivers split a variable
  assign drive_out = '{high_side: (state == DSS_ON), low_side: ls};

  // Switching cycle, dropout skip and soft-start/arming counters
  always_comb begin
    next_state = state;
    next_off_cnt = off_cnt;
    next_skip_cnt = skip_cnt;
    next_pend = pend;
    next_ss_cnt = ss_cnt;
    next_arm_cnt = arm_cnt;
    if (!enable_in) begin
      next_ss_cnt = 10'h000;
      next_arm_cnt = 13'h0000;
    end else if (osc_pulse_in) begin
      if (ss_cnt != SS_FULL_COUNT) begin
        next_ss_cnt = ss_cnt + 10'h001;
      end
      if (!uv_armed_out) begin
        next_arm_cnt = arm_cnt + 13'h0001;
      end
    end
    case (state)
      DSS_IDLE: begin
        next_skip_cnt = 2'h0;
        if (run && osc_pulse_in) begin
          next_state = DSS_ON;
        end
      end
      DSS_ON: begin
        if (!run) begin
          next_state = DSS_IDLE;
        end else if (cmp_in.cur_lim || cmp_in.pwm_trip) begin
          next_state = DSS_MINOFF;
          next_off_cnt = 4'h0;
          next_pend = 1'b0;
        end else if (osc_pulse_in) begin
          // Still low and no current limit: stretch the on-time
          if (!cmp_in.in_reg && skip_cnt != SKIP_MAX) begin
            next_skip_cnt = skip_cnt + 2'h1;
          end else begin
            next_state = DSS_MINOFF;
            next_off_cnt = 4'h0;
            next_pend = 1'b1;
          end
        end
      end
      DSS_MINOFF: begin
        // Clock edges arriving here are remembered, not dropped
        if (osc_pulse_in) begin
          next_pend = 1'b1;
        end
        if (!run) begin
          next_state = DSS_IDLE;
        end else if (off_cnt == MIN_OFF_CYC - 4'h1) begin
          next_state = DSS_WAIT;
        end else begin
          next_off_cnt = off_cnt + 4'h1;
        end
      end
      DSS_WAIT: begin
        if (!run) begin
          next_state = DSS_IDLE;
        end else if (osc_pulse_in || pend) begin
          next_state = DSS_ON;
          next_skip_cnt = 2'h0;
          next_pend = 1'b0;
        end
      end
      default: next_state = DSS_IDLE;
    endcase
    // Low side: clamp wins, then hold when disabled, else on in DSS_MINOFF and DSS_WAIT unless reverse current
    if (clamp_in) begin
      next_ls = 1'b1;
    end else if (!enable_in) begin
      next_ls = hold_low_in;
    end else begin
      next_ls = (next_state != DSS_ON) && (next_state != DSS_IDLE) && !cmp_in.reverse_cur;
    end
  end

  // Registers
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state <= DSS_IDLE;
      off_cnt <= 4'h0;
      skip_cnt <= 2'h0;
      pend <= 1'b0;
      ss_cnt <= 10'h000;
      arm_cnt <= 13'h0000;
      ls <= 1'b0;
    end else begin
      state <= next_state;
      off_cnt <= next_off_cnt;
      skip_cnt <= next_skip_cnt;
      pend <= next_pend;
      ss_cnt <= next_ss_cnt;
      arm_cnt <= next_arm_cnt;
      ls <= next_ls;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking dss_rail_cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  chk_ss_held_zero: assert property (!enable_in |=> ss_cnt == 10'h000)
    else $error("soft-start count not held at zero");
  chk_ss_full_step: assert property ((ss_cnt == SS_FULL_COUNT) |-> ss_step_out == 3'h5)
    else $error("soft-start level not full at 512");
  chk_min_off_time: assert property ($fell(drive_out.high_side) |-> !drive_out.high_side[*6])
    else $error("off-time shorter than minimum");
  chk_limit_ends_on: assert property ((state == DSS_ON && cmp_in.cur_lim) |=> !drive_out.high_side)
    else $error("current limit did not end on-time");
  chk_skip_bound: assert property (skip_cnt == SKIP_MAX && osc_pulse_in && state == DSS_ON
    |=> state != DSS_ON)
    else $error("more than three off-times skipped");
  chk_arm_after_count: assert property ($rose(uv_armed_out) |-> $past(arm_cnt) == 13'(UV_ARM - 1))
    else $error("undervoltage armed at wrong count");
  cov_skip_three: cover property (skip_cnt == SKIP_MAX && state == DSS_ON);

endmodule // dss_rail

// File: dss_host.sv
/* Pin-side model of the system control logic: timing cap and sync clock.
   Assumes the bench puts the wanted pin levels on cmd_in. */
`timescale 1ns/1ps
module dss_host import dss_pkg::*; #(
  parameter int unsigned DLY = 30
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire dss_pins_t cmd_in,
  input wire logic sync_en_in,
  input wire logic discharge_in,
  output dss_pins_t pins_out
);
  int unsigned chg;
  int unsigned ph;
  // Cap charges while master on; the device pulldown empties it
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in || discharge_in) begin
      chg <= 0;
    end else if (cmd_in.master_on_low_rail && chg < DLY) begin
      chg <= chg + 1;
    end
    ph <= (ph >= 43) ? 0 : ph + 1; // 44 clocks, 454 kHz
  end
  // Cap threshold replaces the high-rail input outside reference order
  always_comb begin
    pins_out = cmd_in;
    if (cmd_in.order_select inside {ORDER_VL, ORDER_GND}) begin
      pins_out.delay_or_on_high_rail = (chg >= DLY);
    end
    if (sync_en_in) begin
      pins_out.freq_sel = (ph < 22);
    end
  end
endmodule // dss_host

// File: dual_supply_sequencer_tb_top.sv
/* Self-checking bench of the sequencer with the pin-side model.
   Assumes shortened PG_CYCLES and UV_ARM counts. */
`timescale 1ns/1ps
module dual_supply_sequencer_tb_top import dss_pkg::*; ();
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic sync_en = 1'b0;
  logic f;
  dss_pins_t cmd;
  dss_pins_t pins;
  dss_cmp_t lo;
  dss_cmp_t hi;
  dss_drive_t dl;
  dss_drive_t dh;
  logic [2:0] ss, ssh;
  logic el, eh, pg, dis, mc, rs, uv, ov;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #25 clk_in = ~clk_in;
  dss_host u_host (.clk_in(clk_in), .arst_n_in(arst_n_in), .cmd_in(cmd),
    .sync_en_in(sync_en), .discharge_in(dis), .pins_out(pins));
  dss_top #(.PG_CYCLES(20), .UV_ARM(8)) u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .shutdown_n_in(pins.shutdown_n), .master_on_low_rail_in(pins.master_on_low_rail),
    .delay_or_on_high_rail_in(pins.delay_or_on_high_rail), .freq_sel_in(pins.freq_sel),
    .forced_pwm_in(pins.forced_pwm), .internal_5v_rail_ok_in(pins.internal_5v_rail_ok),
    .input_power_ok_in(pins.input_power_ok), .order_select_in(pins.order_select),
    .cmp_low_in(lo), .cmp_high_in(hi), .drive_low_out(dl), .drive_high_out(dh),
    .ss_step_low_out(ss), .ss_step_high_out(ssh), .rail_low_en_out(el),
    .rail_high_en_out(eh), .power_good_out(pg), .delay_discharge_out(dis),
    .min_current_cmp_en_out(mc), .reverse_thresh_shift_out(rs),
    .uv_latched_out(uv), .ov_latched_out(ov));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #5;
  endtask
  // Reference order: each input owns its rail, {high, low}
  function automatic logic [2:0] ref_en(input logic m, input logic d);
    return {1'b0, d, m};
  endfunction
  task automatic end_sim();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Hang guard well above the 31k clocks the sequence needs
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 45000) begin
      n_fail++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cmd = '0;
    cmd.internal_5v_rail_ok = 1'b1;
    cmd.input_power_ok = 1'b1;
    cmd.master_on_low_rail = 1'b1;
    cmd.delay_or_on_high_rail = 1'b1;
    lo = '0;
    hi = '0;
    void'($urandom(2));
    step(12);
    chk("discharge", 3'h1, {2'h0, dis});
    arst_n_in = 1'b1;
    step(6);
    chk("en", 3'h0, {1'b0, eh, el});
    chk("low_side", 3'h1, {2'h0, dl.low_side});
    cmd.shutdown_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cmd.master_on_low_rail = i[0];
      cmd.delay_or_on_high_rail = i[1];
      step(5);
      chk("en", ref_en(i[0], i[1]), {1'b0, eh, el});
      chk("ls_hi", {2'h0, !i[1]}, {2'h0, dh.low_side});
      if (i == 0) begin
        chk("ss", 3'h0, ss);
        chk("ss_hi", 3'h0, ssh);
        chk("disch", 3'h1, {2'h0, dis});
      end
    end
    repeat (4) begin
      f = 1'($urandom);
      cmd.forced_pwm = f;
      step(5);
      chk("fpwm", {1'b0, !f, f}, {1'b0, mc, rs});
    end
    // Master orders: first rail at once, second after the cap delay
    for (int k = 1; k < 3; k++) begin
      cmd.master_on_low_rail = 1'b0;
      cmd.order_select = 2'(k);
      step(40);
      cmd.master_on_low_rail = 1'b1;
      step(5);
      chk("first", (k == 1) ? 3'h1 : 3'h2, {1'b0, eh, el});
      step(40);
      chk("both", 3'h3, {1'b0, eh, el});
    end
    lo.in_reg = 1'b1;
    step(1500);
    chk("pg", 3'h0, {2'h0, pg});
    hi.in_reg = 1'b1;
    step(1100);
    chk("pg", 3'h0, {2'h0, pg});
    step(200);
    chk("pg", 3'h1, {2'h0, pg});
    cmd.order_select = ORDER_REF;
    hi.in_reg = 1'b0;
    step(10);
    chk("pg", 3'h1, {2'h0, pg});
    // Low rail fault: its arming restarts when the master input toggles
    lo.under = 1'b1;
    step(6);
    chk("uv", 3'h3, {1'b0, uv, dl.low_side & dh.low_side});
    chk("hs", 3'h0, {1'b0, dl.high_side, dh.high_side});
    cmd.master_on_low_rail = 1'b0;
    step(5);
    cmd.master_on_low_rail = 1'b1;
    step(6);
    chk("uv", 3'h0, {2'h0, uv});
    step(500);
    chk("uv", 3'h1, {2'h0, uv});
    lo.under = 1'b0;
    cmd.input_power_ok = 1'b0;
    step(5);
    chk("uv", 3'h0, {2'h0, uv});
    cmd.input_power_ok = 1'b1;
    lo.over = 1'b1;
    step(6);
    lo.over = 1'b0;
    step(20);
    chk("ov", 3'h3, {1'b0, ov, dh.low_side});
    cmd.shutdown_n = 1'b0;
    step(5);
    chk("ov", 3'h0, {2'h0, ov});
    // Static high rate: about 104 pulses in 4200 clocks, one step up
    cmd.freq_sel = 1'b1;
    cmd.shutdown_n = 1'b1;
    step(4200);
    chk("ss", 3'h1, ss);
    // Current-limit burst to reach the on-time cut-off logic
    lo.cur_lim = 1'b1;
    step(8);
    lo.cur_lim = 1'b0;
    cmd.shutdown_n = 1'b0;
    cmd.freq_sel = 1'b0;
    step(5);
    sync_en = 1'b1;
    cmd.shutdown_n = 1'b1;
    step(22000);
    chk("ss", 3'h4, ss);
    step(1000);
    chk("ss", 3'h5, ss);
    chk("ss_hi", 3'h5, ssh);
    end_sim();
  end
endmodule // dual_supply_sequencer_tb_top
